//--- fcp_pkg.sv
// shared constants for the floppy command parameter block
package fcp_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] A_MODE      = 4'h0;
  localparam logic [3:0] A_SIZE      = 4'h1;
  localparam logic [3:0] A_SHORT_LEN = 4'h2;
  localparam logic [3:0] A_START_SEC = 4'h3;
  localparam logic [3:0] A_LAST_SEC  = 4'h4;
  localparam logic [3:0] A_TARGET    = 4'h5;
  localparam logic [3:0] A_SETTLE    = 4'h6;
  localparam logic [3:0] A_RELEASE   = 4'h7;
  localparam logic [3:0] A_CONFIG    = 4'h8;
  localparam logic [3:0] A_PRECOMP   = 4'h9;
  localparam logic [3:0] A_CMD       = 4'hA;
  localparam logic [3:0] A_STATUS    = 4'hB;
  localparam logic [3:0] A_INT_STAT  = 4'hC;
  localparam logic [3:0] A_INT_MASK  = 4'hD;
  localparam logic [3:0] A_DATA      = 4'hE;
  localparam logic [3:0] A_CYL       = 4'hF;
  // mode register fields
  localparam int M_HEAD = 0;
  localparam int M_MFM  = 1;
  localparam int M_MT   = 2;
  localparam int M_NDMA = 3;
  localparam int M_SRST = 7;
  // config register fields
  localparam int C_FEN  = 4;
  localparam int C_LOCK = 5;
  // interrupt status bits
  localparam int I_DREQ = 0;
  localparam int I_DONE = 1;
  localparam int I_ERR  = 2;
  localparam int I_SEEK = 3;
  // commands written to the command register
  localparam logic [7:0] CMD_READ  = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  // reset values
  localparam logic [7:0] RST_SHORT_LEN = 8'hFF;
  localparam logic       RST_FEN_N     = 1'b1;
  localparam logic [3:0] RST_FIFO_THR  = 4'h0;
  localparam logic [7:0] RST_PRECOMP   = 8'h00;
  // sector geometry
  localparam logic [14:0] BASE_LEN  = 15'h0080;
  localparam logic [7:0]  FIRST_SEC = 8'h01;
  localparam logic [15:0] CRC_INIT  = 16'hFFFF;
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  // interval unit: one millisecond at the 20 ns clock
  localparam int TICK_TIME_NS = 1000000;
  localparam int CLK_NS       = 20;
  localparam int TICK_CYCLES  = TICK_TIME_NS / CLK_NS;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SETTLE  = 3'b001,
    ST_SEARCH  = 3'b010,
    ST_DATA    = 3'b011,
    ST_CRC     = 3'b100,
    ST_RELEASE = 3'b101
  } fcp_state_t;
endpackage

//--- fcp_timer.sv
// millisecond tick divider and interval timer
`timescale 1ns/1ns
module fcp_timer #(
  parameter int TICK_CYCLES = fcp_pkg::TICK_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       start_in,
  input  wire logic [7:0] interval_in,
  output logic            tick_out,
  output logic            done_out
);
  logic [19:0] pre;
  logic [7:0]  remain;
  logic        running;

  // free-running divider; restarting a wait does not realign it, so a wait may be short by <1 ms
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre      <= 20'h00000;
      tick_out <= 1'b0;
    end else if (pre == 20'(TICK_CYCLES - 1)) begin
      pre      <= 20'h00000;
      tick_out <= 1'b1;
    end else begin
      pre      <= pre + 20'h00001;
      tick_out <= 1'b0;
    end
  end

  // interval countdown in ticks; a new start overrides a running wait
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      remain   <= 8'h00;
      running  <= 1'b0;
      done_out <= 1'b0;
    end else if (start_in) begin
      remain   <= interval_in;
      running  <= 1'b1;
      done_out <= 1'b0;
    end else if (running && remain == 8'h00) begin
      running  <= 1'b0;
      done_out <= 1'b1;
    end else begin
      done_out <= 1'b0;
      if (running && tick_out) begin
        remain <= remain - 8'h01;
      end
    end
  end
endmodule

//--- fcp_core.sv
// floppy command parameter interpreter: registers, sector sequencer, host transfer
`timescale 1ns/1ns
module fcp_core #(
  parameter int TICK_CYCLES = fcp_pkg::TICK_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            irq_out,
  output logic            drq_out,
  input  wire logic       dack_n_in,
  input  wire logic [7:0] dma_data_in,
  output logic      [7:0] dma_data_out,
  output logic            head_load_out,
  output logic            head_side_out,
  output logic            mfm_out,
  output logic            step_out,
  output logic            step_dir_out,
  output logic            fifo_enable_n_out,
  output logic      [3:0] fifo_threshold_out,
  output logic      [7:0] precomp_start_track_out,
  input  wire logic       id_strobe_in,
  input  wire logic       id_head_in,
  input  wire logic [7:0] id_sector_in,
  input  wire logic       media_strobe_in,
  input  wire logic [7:0] media_data_in,
  output logic      [7:0] media_data_out,
  output logic            media_write_out
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [14:0] sector_len(input logic [2:0] code);
    return fcp_pkg::BASE_LEN << code;
  endfunction

  function automatic logic [14:0] xfer_len(input logic [2:0] code, input logic [7:0] short_sector_length);
    if (code != 3'h0) return sector_len(code);
    return ({7'h00, short_sector_length} < fcp_pkg::BASE_LEN) ? {7'h00, short_sector_length} : fcp_pkg::BASE_LEN;
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ fcp_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  fcp_pkg::fcp_state_t state;
  logic [7:0]  mode, short_len, start_sec, last_sec, target, settle, release_iv;
  logic [7:0]  precomp, int_mask, host_buf, pcn, dack_d1, dack_d2;
  logic [2:0]  size_code;
  logic [3:0]  fifo_thr, int_stat, ev;
  logic        fen_n, lock, cur_head, writing, crc_idx, buf_full, seek_active;
  logic [7:0]  cur_sector;
  logic [14:0] byte_idx, sec_len, xlen;
  logic [15:0] crc, next_crc;
  logic        dack_s1, dack_s2, dack_s3, dack_edge, tick, tmr_done, tmr_start;
  logic        soft_rst, start_cmd, media_take, sec_last, seq_end, crc_bad;
  logic        req, req_prev, xfer_err, seek_done, host_take, host_give;
  logic [7:0]  wr_byte;

  assign soft_rst  = wr_in && addr_in == fcp_pkg::A_MODE && wdata_in[fcp_pkg::M_SRST];
  assign start_cmd = wr_in && addr_in == fcp_pkg::A_CMD && !soft_rst
                     && (wdata_in == fcp_pkg::CMD_READ || wdata_in == fcp_pkg::CMD_WRITE)
                     && (state == fcp_pkg::ST_IDLE || state == fcp_pkg::ST_RELEASE);
  assign sec_len   = sector_len(size_code);
  assign xlen      = xfer_len(size_code, short_len);
  assign media_take = state == fcp_pkg::ST_DATA && media_strobe_in && byte_idx < xlen;
  // excess bytes of a short sector go out as zeros, crc bytes follow the data
  assign wr_byte   = (state == fcp_pkg::ST_CRC) ? (crc_idx ? crc[7:0] : crc[15:8]) :
                     (byte_idx < xlen) ? host_buf : 8'h00;
  assign next_crc  = crc_byte(crc, writing ? wr_byte : media_data_in);
  assign crc_bad   = !writing && next_crc != 16'h0000;
  assign sec_last  = state == fcp_pkg::ST_CRC && media_strobe_in && crc_idx;
  assign seq_end   = sec_last && (crc_bad || (cur_sector == last_sec
                     && !(mode[fcp_pkg::M_MT] && !cur_head)));
  // the head-load wait only runs when the head was unloaded
  assign tmr_start = (start_cmd && state == fcp_pkg::ST_IDLE) || seq_end;
  assign dack_edge = dack_s3 && !dack_s2;

  fcp_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .start_in    (tmr_start),
    .interval_in (seq_end ? release_iv : settle),
    .tick_out    (tick),
    .done_out    (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // software-written configuration
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode <= 8'h00; size_code <= 3'h0; short_len <= fcp_pkg::RST_SHORT_LEN;
      start_sec <= 8'h00; last_sec <= 8'h00; target <= 8'h00; settle <= 8'h00;
      release_iv <= 8'h00; int_mask <= 8'h00; lock <= 1'b0;
      fen_n <= fcp_pkg::RST_FEN_N; fifo_thr <= fcp_pkg::RST_FIFO_THR;
      precomp <= fcp_pkg::RST_PRECOMP;
    end else if (soft_rst) begin
      mode <= {1'b0, wdata_in[6:0]};
      if (!lock) begin
        fen_n    <= fcp_pkg::RST_FEN_N;
        fifo_thr <= fcp_pkg::RST_FIFO_THR;
        precomp  <= fcp_pkg::RST_PRECOMP;
      end
    end else if (wr_in) begin
      case (addr_in)
        fcp_pkg::A_MODE:      mode <= wdata_in;
        fcp_pkg::A_SIZE:      size_code <= wdata_in[2:0];
        fcp_pkg::A_SHORT_LEN: short_len <= wdata_in;
        fcp_pkg::A_START_SEC: start_sec <= wdata_in;
        fcp_pkg::A_LAST_SEC:  last_sec <= wdata_in;
        fcp_pkg::A_TARGET:    target <= wdata_in;
        fcp_pkg::A_SETTLE:    settle <= wdata_in;
        fcp_pkg::A_RELEASE:   release_iv <= wdata_in;
        fcp_pkg::A_INT_MASK:  int_mask <= wdata_in;
        fcp_pkg::A_PRECOMP:   precomp <= wdata_in;
        fcp_pkg::A_CONFIG: begin
          fifo_thr <= wdata_in[3:0];
          fen_n    <= wdata_in[fcp_pkg::C_FEN];
          lock     <= wdata_in[fcp_pkg::C_LOCK];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sector sequencer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= fcp_pkg::ST_IDLE; head_load_out <= 1'b0; cur_head <= 1'b0;
      cur_sector <= 8'h00; writing <= 1'b0; byte_idx <= 15'h0000; crc_idx <= 1'b0;
    end else if (soft_rst) begin
      state <= fcp_pkg::ST_IDLE;
      head_load_out <= 1'b0;
    end else begin
      case (state)
        fcp_pkg::ST_IDLE, fcp_pkg::ST_RELEASE: begin
          if (start_cmd) begin
            cur_head   <= mode[fcp_pkg::M_HEAD];
            cur_sector <= start_sec;
            writing    <= wdata_in == fcp_pkg::CMD_WRITE;
            head_load_out <= 1'b1;
            state <= (state == fcp_pkg::ST_IDLE) ? fcp_pkg::ST_SETTLE : fcp_pkg::ST_SEARCH;
          end else if (state == fcp_pkg::ST_RELEASE && tmr_done) begin
            head_load_out <= 1'b0;
            state <= fcp_pkg::ST_IDLE;
          end
        end
        fcp_pkg::ST_SETTLE: if (tmr_done) state <= fcp_pkg::ST_SEARCH;
        fcp_pkg::ST_SEARCH: begin
          if (id_strobe_in && id_head_in == cur_head && id_sector_in == cur_sector) begin
            byte_idx <= 15'h0000;
            state <= fcp_pkg::ST_DATA;
          end
        end
        fcp_pkg::ST_DATA: begin
          if (media_strobe_in) begin
            byte_idx <= byte_idx + 15'h0001;
            if (byte_idx == sec_len - 15'h0001) begin
              crc_idx <= 1'b0;
              state <= fcp_pkg::ST_CRC;
            end
          end
        end
        fcp_pkg::ST_CRC: begin
          if (media_strobe_in) crc_idx <= 1'b1;
          if (seq_end) begin
            state <= fcp_pkg::ST_RELEASE;
          end else if (sec_last && cur_sector == last_sec) begin
            cur_head   <= 1'b1;
            cur_sector <= fcp_pkg::FIRST_SEC;
            state <= fcp_pkg::ST_SEARCH;
          end else if (sec_last) begin
            cur_sector <= cur_sector + 8'h01;
            state <= fcp_pkg::ST_SEARCH;
          end
        end
        default: state <= fcp_pkg::ST_IDLE;
      endcase
    end
  end

  // crc runs over every byte of the physical sector; written crc bytes are not folded in
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crc <= fcp_pkg::CRC_INIT; media_data_out <= 8'h00;
    end else begin
      if (state == fcp_pkg::ST_SEARCH) crc <= fcp_pkg::CRC_INIT;
      else if (media_strobe_in && (state == fcp_pkg::ST_DATA
               || (state == fcp_pkg::ST_CRC && !writing))) crc <= next_crc;
      if (media_strobe_in && writing) media_data_out <= wr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-byte host buffer shared by the register port and the DMA handshake
  assign host_take = (rd_in && addr_in == fcp_pkg::A_DATA) || (dack_edge && !writing);
  assign host_give = (wr_in && addr_in == fcp_pkg::A_DATA) || (dack_edge && writing);
  assign xfer_err  = media_take && (writing ? !buf_full : (buf_full && !host_take));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      host_buf <= 8'h00; buf_full <= 1'b0;
    end else if (start_cmd || soft_rst) begin
      buf_full <= 1'b0;
    end else if (writing) begin
      if (media_take) buf_full <= 1'b0;
      if (host_give) begin
        host_buf <= (dack_edge) ? dack_d2 : wdata_in;
        buf_full <= 1'b1;
      end
    end else begin
      if (host_take) buf_full <= 1'b0;
      if (media_take) begin
        host_buf <= media_data_in;
        buf_full <= 1'b1;
      end
    end
  end

  // request a byte while the direction needs one; writes prefetch the next byte
  always_comb begin
    req = 1'b0;
    if (writing) req = !buf_full && (state == fcp_pkg::ST_SETTLE
                 || state == fcp_pkg::ST_SEARCH
                 || (state == fcp_pkg::ST_DATA && byte_idx + 15'h0001 < xlen));
    else req = buf_full && state != fcp_pkg::ST_IDLE;
  end
  assign drq_out      = req && !mode[fcp_pkg::M_NDMA];
  assign dma_data_out = host_buf;

  // dack and its data are pins; both pass two flops before use
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dack_s1 <= 1'b1; dack_s2 <= 1'b1; dack_s3 <= 1'b1;
      dack_d1 <= 8'h00; dack_d2 <= 8'h00; req_prev <= 1'b0;
    end else begin
      dack_s1 <= dack_n_in; dack_s2 <= dack_s1; dack_s3 <= dack_s2;
      dack_d1 <= dma_data_in; dack_d2 <= dack_d1;
      req_prev <= req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // head positioning toward the target cylinder, one step per tick
  assign seek_done = tick && seek_active && pcn == target;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seek_active <= 1'b0; pcn <= 8'h00; step_out <= 1'b0; step_dir_out <= 1'b0;
    end else begin
      step_out <= 1'b0;
      if (soft_rst) seek_active <= 1'b0;
      else if (wr_in && addr_in == fcp_pkg::A_TARGET) seek_active <= 1'b1;
      else if (seek_done) seek_active <= 1'b0;
      else if (tick && seek_active) begin
        step_out     <= 1'b1;
        step_dir_out <= target > pcn;
        pcn <= (target > pcn) ? pcn + 8'h01 : pcn - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear, a new event wins over the clear
  assign ev = {seek_done, xfer_err || (sec_last && crc_bad), seq_end,
               req && !req_prev && mode[fcp_pkg::M_NDMA]};
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) int_stat <= 4'h0;
    else if (wr_in && addr_in == fcp_pkg::A_INT_STAT) int_stat <= (int_stat & ~wdata_in[3:0]) | ev;
    else int_stat <= int_stat | ev;
  end
  assign irq_out = |(int_stat & int_mask[3:0]);

  // read data one cycle after the strobe; unused size, config and interrupt status bits read zero, unused mode and mask bits read as written
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rdata_out <= 8'h00;
    else if (rd_in) begin
      case (addr_in)
        fcp_pkg::A_MODE:      rdata_out <= mode;
        fcp_pkg::A_SIZE:      rdata_out <= {5'h00, size_code};
        fcp_pkg::A_SHORT_LEN: rdata_out <= short_len;
        fcp_pkg::A_START_SEC: rdata_out <= start_sec;
        fcp_pkg::A_LAST_SEC:  rdata_out <= last_sec;
        fcp_pkg::A_TARGET:    rdata_out <= target;
        fcp_pkg::A_SETTLE:    rdata_out <= settle;
        fcp_pkg::A_RELEASE:   rdata_out <= release_iv;
        fcp_pkg::A_CONFIG:    rdata_out <= {2'h0, lock, fen_n, fifo_thr};
        fcp_pkg::A_PRECOMP:   rdata_out <= precomp;
        fcp_pkg::A_STATUS:    rdata_out <= {state != fcp_pkg::ST_IDLE, head_load_out,
                                            cur_head, writing, buf_full, seek_active,
                                            crc_idx, req};
        fcp_pkg::A_INT_STAT:  rdata_out <= {4'h0, int_stat};
        fcp_pkg::A_INT_MASK:  rdata_out <= int_mask;
        fcp_pkg::A_DATA:      rdata_out <= host_buf;
        fcp_pkg::A_CYL:       rdata_out <= pcn;
        default:              rdata_out <= 8'h00;
      endcase
    end
  end

  assign head_side_out           = cur_head;
  assign mfm_out                 = mode[fcp_pkg::M_MFM];
  assign media_write_out         = writing && (state == fcp_pkg::ST_DATA
                                   || state == fcp_pkg::ST_CRC);
  assign fifo_enable_n_out       = fen_n;
  assign fifo_threshold_out      = fifo_thr;
  assign precomp_start_track_out = precomp;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_last_of_head0;
    sec_last && !crc_bad && cur_sector == last_sec && mode[fcp_pkg::M_MT] && !cur_head;
  endsequence
  sequence s_on_head1_first;
    cur_head && cur_sector == fcp_pkg::FIRST_SEC && state == fcp_pkg::ST_SEARCH;
  endsequence

  property p_id_match;
    @(posedge clk_in) disable iff (!rst_n_in)
    state == fcp_pkg::ST_SEARCH && id_strobe_in && id_head_in != cur_head
    |=> state != fcp_pkg::ST_DATA;
  endproperty
  a_id_match: assert property (p_id_match) else $error("data entered on wrong head");

  property p_settle;
    @(posedge clk_in) disable iff (!rst_n_in)
    $past(state) == fcp_pkg::ST_SETTLE && state == fcp_pkg::ST_SEARCH |-> $past(tmr_done);
  endproperty
  a_settle: assert property (p_settle) else $error("search began before settle");

  property p_release;
    @(posedge clk_in) disable iff (!rst_n_in)
    state == fcp_pkg::ST_RELEASE && tmr_done && !start_cmd && !soft_rst
    |=> !head_load_out ##1 !head_load_out;
  endproperty
  a_release: assert property (p_release) else $error("head not unloaded");

  property p_lock_keeps;
    @(posedge clk_in) disable iff (!rst_n_in)
    soft_rst && lock |=> $stable(fifo_thr) && $stable(precomp) && $stable(fen_n);
  endproperty
  a_lock_keeps: assert property (p_lock_keeps) else $error("locked config lost");

  property p_unlock_resets;
    @(posedge clk_in) disable iff (!rst_n_in)
    soft_rst && !lock |=> fen_n == fcp_pkg::RST_FEN_N && fifo_thr == fcp_pkg::RST_FIFO_THR
    && precomp == fcp_pkg::RST_PRECOMP;
  endproperty
  a_unlock_resets: assert property (p_unlock_resets) else $error("config not reset");

  property p_density;
    @(posedge clk_in) disable iff (!rst_n_in)
    wr_in && addr_in == fcp_pkg::A_MODE |=> mfm_out == $past(wdata_in[fcp_pkg::M_MFM]);
  endproperty
  a_density: assert property (p_density) else $error("density not applied");

  property p_multi_track;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_last_of_head0 |=> s_on_head1_first;
  endproperty
  a_multi_track: assert property (p_multi_track) else $error("no switch to head 1");

  property p_single_head;
    @(posedge clk_in) disable iff (!rst_n_in)
    sec_last && cur_sector == last_sec && !mode[fcp_pkg::M_MT]
    |=> state == fcp_pkg::ST_RELEASE && $stable(cur_head);
  endproperty
  a_single_head: assert property (p_single_head) else $error("head switched");

  property p_short_drop;
    @(posedge clk_in) disable iff (!rst_n_in)
    state == fcp_pkg::ST_DATA && media_strobe_in && !writing && byte_idx >= xlen
    && !host_take |=> $stable(buf_full) && $stable(host_buf);
  endproperty
  a_short_drop: assert property (p_short_drop) else $error("excess passed to host");

  property p_zero_fill;
    @(posedge clk_in) disable iff (!rst_n_in)
    state == fcp_pkg::ST_DATA && media_strobe_in && writing && byte_idx >= xlen
    |=> media_data_out == 8'h00;
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("excess not zero");

  property p_pio_irq;
    @(posedge clk_in) disable iff (!rst_n_in)
    mode[fcp_pkg::M_NDMA] && req && !req_prev |=> int_stat[fcp_pkg::I_DREQ] && !drq_out;
  endproperty
  a_pio_irq: assert property (p_pio_irq) else $error("no per-byte interrupt");

  property p_step;
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(step_out) |-> $past(pcn) != $past(target);
  endproperty
  a_step: assert property (p_step) else $error("step at target");
endmodule

//--- fcp_dma_model.sv
// dma controller model answering byte requests from the core
`timescale 1ns/1ns
module fcp_dma_model (
  input  wire logic       clk_in,
  input  wire logic       drq_in,
  input  wire logic [7:0] data_in,
  output logic            dack_n_out,
  output logic      [7:0] data_out,
  output logic      [7:0] got_out
);
  logic [7:0] byte_seen;
  // acknowledge each request for four cycles; the core resyncs dack, so it must be long
  // request and data are looked at mid-cycle, away from the edge that launches them
  initial begin
    dack_n_out = 1'b1;
    got_out = 8'h00;
    forever begin
      @(negedge clk_in);
      if (drq_in === 1'b1) begin
        byte_seen = data_in;
        @(posedge clk_in);
        dack_n_out <= 1'b0;
        got_out <= byte_seen;
        repeat (4) @(posedge clk_in);
        dack_n_out <= 1'b1;
        repeat (6) @(posedge clk_in);
      end
    end
  end
  // write data shows a changing value, never a stale byte
  assign data_out = ~got_out;
endmodule

//--- fcp_core_test.sv
// self-checking bench for the floppy command parameter core
`timescale 1ns/1ns
module fcp_core_test;
  logic clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, dack_n, ids = 0, ms = 0, idh = 0;
  logic [3:0] addr_in = 4'h0, thr;
  logic [7:0] wdata_in = 8'h00, rdata_out, dd_in, dd_out, got, md = 8'h00, pre, v, mdo;
  logic irq_out, drq_out, hl, hs, mfm, fen, sdir;
  logic [15:0] crc_exp;
  int n_errors = 0, compares = 0, i;
  always #10 clk_in = ~clk_in;
  fcp_core #(.TICK_CYCLES(20)) u_fcp_core (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .drq_out(drq_out), .dack_n_in(dack_n),
    .dma_data_in(dd_in), .dma_data_out(dd_out), .head_load_out(hl), .head_side_out(hs),
    .mfm_out(mfm), .step_out(), .step_dir_out(sdir), .fifo_enable_n_out(fen),
    .fifo_threshold_out(thr), .precomp_start_track_out(pre), .id_strobe_in(ids),
    .id_head_in(idh), .id_sector_in(md), .media_strobe_in(ms), .media_data_in(md),
    .media_data_out(mdo), .media_write_out());
  fcp_dma_model u_fcp_dma_model (.clk_in(clk_in), .drq_in(drq_out), .data_in(dd_out),
    .dack_n_out(dack_n), .data_out(dd_in), .got_out(got));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (exp !== seen) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // one id or media byte slot on the drive side
  task slot(input logic h, input logic is_id, input logic [7:0] b);
    @(posedge clk_in);
    idh <= h; ids <= is_id; ms <= ~is_id; md <= b;
    @(posedge clk_in);
    ids <= 1'b0; ms <= 1'b0;
  endtask
  // one 128-byte sector: id for sector 1, first byte f then b, then the crc the medium holds
  task sector(input logic h, input logic [7:0] f, input logic [7:0] b);
    logic [7:0] d;
    repeat (4) @(posedge clk_in);
    crc_exp = fcp_pkg::CRC_INIT;
    slot(h, 1'b1, 8'h01);
    for (int k = 0; k < 128; k++) begin
      d = (k == 0) ? f : b;
      crc_exp = crc_exp ^ {d, 8'h00};
      for (int j = 0; j < 8; j++)
        crc_exp = crc_exp[15] ? (crc_exp << 1) ^ fcp_pkg::CRC_POLY : crc_exp << 1;
      slot(h, 1'b0, d);
    end
    slot(h, 1'b0, crc_exp[15:8]); slot(h, 1'b0, crc_exp[7:0]);
    #1;
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4000) @(posedge clk_in);
    n_errors++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk("fen", 8'h01, {7'h0, fen});
    rd(fcp_pkg::A_SHORT_LEN, v); chk("short_len", 8'hFF, v);
    $display("reset test done");
    // locked settings survive a soft reset, unlocked ones fall back
    wr(fcp_pkg::A_CONFIG, 8'h25); wr(fcp_pkg::A_PRECOMP, 8'h22); wr(fcp_pkg::A_MODE, 8'h80);
    chk("thr", 8'h05, {4'h0, thr}); chk("pre", 8'h22, pre); chk("fen", 8'h00, {7'h0, fen});
    wr(fcp_pkg::A_CONFIG, 8'h05); wr(fcp_pkg::A_MODE, 8'h80);
    chk("thr", 8'h00, {4'h0, thr}); chk("pre", 8'h00, pre); chk("fen", 8'h01, {7'h0, fen});
    wr(fcp_pkg::A_MODE, 8'h02); chk("mfm", 8'h01, {7'h0, mfm});
    wr(fcp_pkg::A_MODE, 8'h00); chk("mfm", 8'h00, {7'h0, mfm});
    $display("config test done");
    // seek completion raises a masked event, then unmask and clear it
    wr(fcp_pkg::A_INT_MASK, 8'h00); wr(fcp_pkg::A_TARGET, 8'h02);
    for (i = 0; i < 100 && v !== 8'h02; i++) rd(fcp_pkg::A_CYL, v);
    // completion is flagged one tick after the last step
    repeat (25) @(posedge clk_in);
    chk("cyl", 8'h02, v); chk("irq masked", 8'h00, {7'h0, irq_out});
    chk("dir", 8'h01, {7'h0, sdir}); rd(fcp_pkg::A_INT_STAT, v); chk("seek ev", 8'h08, v);
    wr(fcp_pkg::A_INT_MASK, 8'h08); chk("irq", 8'h01, {7'h0, irq_out});
    wr(fcp_pkg::A_INT_STAT, 8'h08); chk("irq clr", 8'h00, {7'h0, irq_out});
    $display("seek test done");
    // dma read on head 1: an id for head 0 must not start the data phase
    wr(fcp_pkg::A_MODE, 8'h01); wr(fcp_pkg::A_SETTLE, 8'h00); wr(fcp_pkg::A_SIZE, 8'h00);
    wr(fcp_pkg::A_START_SEC, 8'h01); wr(fcp_pkg::A_LAST_SEC, 8'h01);
    wr(fcp_pkg::A_CMD, fcp_pkg::CMD_READ);
    chk("head load", 8'h01, {7'h0, hl}); chk("side", 8'h01, {7'h0, hs});
    repeat (5) @(posedge clk_in);
    slot(1'b0, 1'b1, 8'h01); slot(1'b0, 1'b0, 8'h11);
    slot(1'b1, 1'b1, 8'h01); slot(1'b0, 1'b0, 8'h5A);
    for (i = 0; i < 40 && got !== 8'h5A; i++) @(posedge clk_in);
    chk("dma byte", 8'h5A, got);
    wr(fcp_pkg::A_MODE, 8'h80); chk("unload", 8'h00, {7'h0, hl});
    $display("dma read test done");
    // pio multi-track read of short sectors: one byte kept, excess dropped, then head 1
    wr(fcp_pkg::A_SHORT_LEN, 8'h01); wr(fcp_pkg::A_MODE, 8'h0C);
    wr(fcp_pkg::A_CMD, fcp_pkg::CMD_READ); sector(1'b0, 8'hA5, 8'h3C);
    chk("mt side", 8'h01, {7'h0, hs}); chk("pio drq", 8'h00, {7'h0, drq_out});
    rd(fcp_pkg::A_DATA, v); chk("pio byte", 8'hA5, v);
    sector(1'b1, 8'h11, 8'h22); repeat (5) @(posedge clk_in);
    chk("unload", 8'h00, {7'h0, hl});
    rd(fcp_pkg::A_INT_STAT, v); chk("pio events", 8'h03, v);
    wr(fcp_pkg::A_MODE, 8'h08); wr(fcp_pkg::A_CMD, fcp_pkg::CMD_READ);
    sector(1'b0, 8'h01, 8'h02); chk("one head", 8'h00, {7'h0, hs});
    $display("pio read test done");
    // pio write of a short sector: excess goes out as zeros, crc over the whole sector
    wr(fcp_pkg::A_INT_STAT, 8'h0F); wr(fcp_pkg::A_CMD, fcp_pkg::CMD_WRITE);
    wr(fcp_pkg::A_DATA, 8'h77);
    sector(1'b0, 8'h77, 8'h00); chk("crc lo", crc_exp[7:0], mdo);
    repeat (5) @(posedge clk_in);
    rd(fcp_pkg::A_INT_STAT, v); chk("write events", 8'h03, v);
    $display("write test done");
    close_out;
  end
endmodule
